// *** logic/pspc_access_class.v ***
// Access class encoder: maps privilege and reference kind to the
// three class lines. Purely combinational, same clock as the caller.
`timescale 1ns/1ps
module pspc_access_class (
    supervisor,
    cpu_space,
    program_ref,
    ref_valid,
    class_code
);
    `include "pspc_defines.vh"
    input wire supervisor;
    input wire cpu_space;
    input wire program_ref;
    input wire ref_valid;
    output reg [2:0] class_code;

    always @* begin
        if (!ref_valid) begin
            class_code = `PSPC_FC_NONE;
        end else if (cpu_space) begin
            class_code = `PSPC_FC_CPU;
        end else if (supervisor) begin
            class_code = program_ref ? `PSPC_FC_SUP_PROG
                                     : `PSPC_FC_SUP_DATA;
        end else begin
            class_code = program_ref ? `PSPC_FC_USER_PROG
                                     : `PSPC_FC_USER_DATA;
        end
    end
endmodule // pspc_access_class

// *** logic/pspc_ctrl.v ***
// Processing state and privilege control with an APB register slave.
// Assumes a decoder presents instruction classes and a bus unit that
// asks for references; all inputs come from pclk logic except the
// irq and bus error pins, which are synchronised here.
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module pspc_ctrl (
    pclk,
    presetn,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    prdata,
    pready,
    pslverr,
    instr_valid,
    instr_class,
    new_status_word,
    ref_req,
    ref_program,
    ref_cpu_space,
    ref_uses_sp,
    irq_pin,
    bus_err_pin,
    instr_accept,
    privilege_violation,
    access_class,
    ref_grant,
    supervisor_mode,
    stack_sel_supervisor,
    active_stack_pointer,
    processing_state,
    saved_supervisor,
    halted,
    stopped
);
    `include "pspc_defines.vh"
    input wire pclk;
    input wire presetn;
    input wire psel;
    input wire penable;
    input wire pwrite;
    input wire [11:0] paddr;
    input wire [31:0] pwdata;
    output reg [31:0] prdata;
    output reg pready;
    output reg pslverr;
    input wire instr_valid;
    input wire [3:0] instr_class;
    input wire [15:0] new_status_word;
    input wire ref_req;
    input wire ref_program;
    input wire ref_cpu_space;
    input wire ref_uses_sp;
    input wire irq_pin;
    input wire bus_err_pin;
    output reg instr_accept;
    output reg privilege_violation;
    output reg [2:0] access_class;
    output reg ref_grant;
    output reg supervisor_mode;
    output reg stack_sel_supervisor;
    output reg [31:0] active_stack_pointer;
    output reg [2:0] processing_state;
    output reg saved_supervisor;
    output reg halted;
    output reg stopped;

    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [15:0] status_word_reg;
    reg [15:0] status_word_next;
    reg saved_s_reg;
    reg saved_s_next;
    reg [2:0] cause_reg;
    reg [2:0] cause_next;
    reg [3:0] exc_cnt_reg;
    reg [3:0] exc_cnt_next;
    reg [31:0] ssp_reg;
    reg [31:0] usp_reg;
    reg [31:0] ctrl_reg;
    reg [1:0] irq_sync_reg;
    reg [1:0] berr_sync_reg;
    wire irq_s;
    wire berr_s;
    wire sup;
    wire is_priv;
    wire priv_fault;
    wire exec_ok;
    wire refs_allowed;
    wire berr_take;
    wire exc_take;
    wire [2:0] class_code;
    wire apb_wr;
    reg [31:0] rdata_mux;
    reg known_addr;

    // Two stages on each pin; only the second stage is read
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_sync_reg <= 2'h0;
            berr_sync_reg <= 2'h0;
        end else begin
            irq_sync_reg <= {irq_sync_reg[0], irq_pin};
            berr_sync_reg <= {berr_sync_reg[0], bus_err_pin};
        end
    end
    assign irq_s = irq_sync_reg[1];
    assign berr_s = berr_sync_reg[1];

    assign sup = status_word_reg[`PSPC_SW_S_BIT];

    // Privileged classes; the extra status word read, control move and alternate space move only with the loop variant
    assign is_priv = (instr_class == `PSPC_OP_WAIT) ||
                     (instr_class == `PSPC_OP_RESTART) ||
                     (instr_class == `PSPC_OP_WRITE_SW) ||
                     (instr_class == `PSPC_OP_RETURN) ||
                     (instr_class == `PSPC_OP_WR_USP) ||
                     (instr_class == `PSPC_OP_RD_USP) ||
                     (ctrl_reg[`PSPC_CTRL_LOOP_EN] &&
                      ((instr_class == `PSPC_OP_RD_SW) ||
                       (instr_class == `PSPC_OP_CTRL_MOVE) ||
                       (instr_class == `PSPC_OP_ALT_MOVE)));

    assign exec_ok = (state_reg == `PSPC_ST_NORMAL) ||
                     (state_reg == `PSPC_ST_LOOP);
    // Supervisor never faults user faults on privileged
    assign priv_fault = instr_valid && exec_ok && !sup && is_priv;

    // A bus error outranks the fault; any exception taken this cycle
    // pre-empts the instruction, so it is never reported as accepted.
    assign berr_take = berr_s && exec_ok;
    assign exc_take = berr_take || priv_fault || (exec_ok && irq_s);

    // No references while stopped or halted; loop mode is operand only
    assign refs_allowed = ref_req &&
        ((state_reg == `PSPC_ST_NORMAL) ||
         (state_reg == `PSPC_ST_EXCEPT) ||
         ((state_reg == `PSPC_ST_LOOP) && !ref_program));

    pspc_access_class u_class (
        .supervisor(sup),
        .cpu_space(ref_cpu_space),
        .program_ref(ref_program),
        .ref_valid(refs_allowed),
        .class_code(class_code)
    );

    always @* begin
        state_next = state_reg;
        status_word_next = status_word_reg;
        saved_s_next = saved_s_reg;
        cause_next = cause_reg;
        exc_cnt_next = exc_cnt_reg;
        case (state_reg)
            `PSPC_ST_NORMAL, `PSPC_ST_LOOP, `PSPC_ST_STOPPED: begin
                if (berr_take) begin
                    state_next = `PSPC_ST_EXCEPT;
                    cause_next = `PSPC_EXC_BUS_ERR;
                end else if (priv_fault) begin
                    state_next = `PSPC_ST_EXCEPT;
                    cause_next = `PSPC_EXC_PRIV;
                end else if (irq_s) begin
                    state_next = `PSPC_ST_EXCEPT;
                    cause_next = `PSPC_EXC_IRQ;
                end else if (instr_valid && exec_ok) begin
                    case (instr_class)
                        `PSPC_OP_WAIT: begin
                            state_next = `PSPC_ST_STOPPED;
                        end
                        `PSPC_OP_LOOP: begin
                            if (ctrl_reg[`PSPC_CTRL_LOOP_EN]) begin
                                state_next = `PSPC_ST_LOOP;
                            end
                        end
                        `PSPC_OP_WRITE_SW, `PSPC_OP_RETURN: begin
                            // Only reached in supervisor mode
                            status_word_next = new_status_word;
                            state_next = `PSPC_ST_NORMAL;
                        end
                        `PSPC_OP_PLAIN: begin
                            if (state_reg == `PSPC_ST_LOOP) begin
                                state_next = `PSPC_ST_NORMAL;
                            end
                        end
                        default: begin
                            state_next = state_reg;
                        end
                    endcase
                end
            end
            `PSPC_ST_EXCEPT: begin
                if (berr_s && cause_reg == `PSPC_EXC_BUS_ERR &&
                    exc_cnt_reg != 4'h0) begin
                    state_next = `PSPC_ST_HALTED;
                end else if (exc_cnt_reg == 4'h0) begin
                    // Save flag, then enter supervisor mode
                    saved_s_next = sup;
                    status_word_next[`PSPC_SW_S_BIT] = 1'b1;
                    exc_cnt_next = exc_cnt_reg + 4'h1;
                end else if (exc_cnt_reg == `PSPC_EXC_CYCLES) begin
                    state_next = `PSPC_ST_NORMAL;
                    exc_cnt_next = 4'h0;
                    // Limitation: the cause reads back only while the
                    // exception is being processed or after a bus error halts
                    cause_next = `PSPC_EXC_NONE;
                end else begin
                    exc_cnt_next = exc_cnt_reg + 4'h1;
                end
            end
            `PSPC_ST_HALTED: begin
                state_next = `PSPC_ST_HALTED;
            end
            default: begin
                state_next = `PSPC_ST_HALTED;
            end
        endcase
    end

    // Reset enters exception processing in supervisor mode
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= `PSPC_ST_EXCEPT;
            status_word_reg <= `PSPC_SW_RESET;
            saved_s_reg <= 1'b1;
            cause_reg <= `PSPC_EXC_RESET;
            exc_cnt_reg <= 4'h0;
        end else begin
            state_reg <= state_next;
            status_word_reg <= status_word_next;
            saved_s_reg <= saved_s_next;
            cause_reg <= cause_next;
            exc_cnt_reg <= exc_cnt_next;
        end
    end

    // APB slave: zero wait states, error on unmapped address
    assign apb_wr = psel && penable && pwrite && pready;

    always @* begin
        known_addr = 1'b1;
        rdata_mux = 32'h0000_0000;
        if (paddr == `PSPC_ADDR_CTRL) begin
            rdata_mux = ctrl_reg;
        end else if (paddr == `PSPC_ADDR_STATUS_WORD) begin
            rdata_mux = {16'h0000, status_word_reg};
        end else if (paddr == `PSPC_ADDR_SSP) begin
            rdata_mux = ssp_reg;
        end else if (paddr == `PSPC_ADDR_USP) begin
            rdata_mux = usp_reg;
        end else if (paddr == `PSPC_ADDR_STATE) begin
            rdata_mux = {27'h0000000, saved_s_reg, state_reg, sup};
        end else if (paddr == `PSPC_ADDR_CAUSE) begin
            rdata_mux = {29'h00000000, cause_reg};
        end else begin
            known_addr = 1'b0;
        end
    end

    // Stack pointers are software loaded; the status word is read only
    // here so user code cannot slip into supervisor mode by the bus.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= 32'h0000_0000;
            ssp_reg <= `PSPC_SP_RESET;
            usp_reg <= `PSPC_SP_RESET;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !known_addr;
            if (psel && !penable && !pwrite) begin
                prdata <= rdata_mux;
            end
            if (apb_wr && known_addr) begin
                if (paddr == `PSPC_ADDR_CTRL) begin
                    ctrl_reg <= {31'h00000000,
                                 pwdata[`PSPC_CTRL_LOOP_EN]};
                end else if (paddr == `PSPC_ADDR_SSP) begin
                    ssp_reg <= pwdata;
                end else if (paddr == `PSPC_ADDR_USP) begin
                    usp_reg <= pwdata;
                end
            end
        end
    end

    // Registered outputs; each lags the internal state by one cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_accept <= 1'b0;
            privilege_violation <= 1'b0;
            access_class <= `PSPC_FC_NONE;
            ref_grant <= 1'b0;
            supervisor_mode <= 1'b1;
            stack_sel_supervisor <= 1'b1;
            active_stack_pointer <= `PSPC_SP_RESET;
            processing_state <= `PSPC_ST_EXCEPT;
            saved_supervisor <= 1'b1;
            halted <= 1'b0;
            stopped <= 1'b0;
        end else begin
            instr_accept <= instr_valid && exec_ok && !exc_take;
            privilege_violation <= priv_fault && !berr_take;
            access_class <= class_code;
            ref_grant <= refs_allowed;
            supervisor_mode <= sup;
            stack_sel_supervisor <= sup;
            active_stack_pointer <= sup ? ssp_reg
                                        : usp_reg;
            processing_state <= state_reg;
            saved_supervisor <= saved_s_reg;
            halted <= (state_reg == `PSPC_ST_HALTED);
            stopped <= (state_reg == `PSPC_ST_STOPPED);
        end
    end
endmodule // pspc_ctrl

// *** logic/pspc_defines.vh ***
// Constants for the processing state and privilege control block.
// Assumes inclusion by bare name from logic files; definitions only.
`ifndef PSPC_DEFINES_VH
`define PSPC_DEFINES_VH

// Byte addresses of the APB registers
`define PSPC_ADDR_CTRL 12'h000
`define PSPC_ADDR_STATUS_WORD 12'h004
`define PSPC_ADDR_SSP 12'h008
`define PSPC_ADDR_USP 12'h00c
`define PSPC_ADDR_STATE 12'h010
`define PSPC_ADDR_CAUSE 12'h014

// Status word fields
`define PSPC_SW_S_BIT 13
`define PSPC_SW_RESET 16'h2700
`define PSPC_SP_RESET 32'h0000_0000

// Control register bits
`define PSPC_CTRL_LOOP_EN 0

// Processing states
`define PSPC_ST_NORMAL 3'h0
`define PSPC_ST_STOPPED 3'h1
`define PSPC_ST_LOOP 3'h2
`define PSPC_ST_EXCEPT 3'h3
`define PSPC_ST_HALTED 3'h4

// Instruction class codes presented by the decoder
`define PSPC_OP_PLAIN 4'h0
`define PSPC_OP_WAIT 4'h1
`define PSPC_OP_RESTART 4'h2
`define PSPC_OP_WRITE_SW 4'h3
`define PSPC_OP_WR_USP 4'h4
`define PSPC_OP_RD_USP 4'h5
`define PSPC_OP_RD_SW 4'h6
`define PSPC_OP_CTRL_MOVE 4'h7
`define PSPC_OP_ALT_MOVE 4'h8
`define PSPC_OP_LOOP 4'h9
`define PSPC_OP_RETURN 4'ha

// Access class codes
`define PSPC_FC_USER_DATA 3'h1
`define PSPC_FC_USER_PROG 3'h2
`define PSPC_FC_SUP_DATA 3'h5
`define PSPC_FC_SUP_PROG 3'h6
`define PSPC_FC_CPU 3'h7
`define PSPC_FC_NONE 3'h0

// Exception cause codes
`define PSPC_EXC_NONE 3'h0
`define PSPC_EXC_RESET 3'h1
`define PSPC_EXC_BUS_ERR 3'h2
`define PSPC_EXC_PRIV 3'h3
`define PSPC_EXC_INTERNAL 3'h4
`define PSPC_EXC_IRQ 3'h5

// Final count of exception processing; five cycles pass before the handler runs
`define PSPC_EXC_CYCLES 4'h4

`endif

// *** tb/pspc_ctrl_sva.sv ***
// Concurrent checks on the state and privilege outputs of pspc_ctrl.
// Assumes one clock pclk and an asynchronous active-low presetn.
`timescale 1ns/1ps
`include "pspc_defines.vh"
module pspc_ctrl_sva (
    input wire pclk,
    input wire presetn,
    input wire privilege_violation,
    input wire [2:0] access_class,
    input wire ref_grant,
    input wire supervisor_mode,
    input wire stack_sel_supervisor,
    input wire [2:0] processing_state,
    input wire halted,
    input wire stopped
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    chk_state_legal: assert property (
        processing_state <= `PSPC_ST_HALTED) else $error("bad state code");
    chk_halt_apart: assert property (!(halted && stopped) &&
        (halted == (processing_state == `PSPC_ST_HALTED)))
        else $error("halted and stopped mixed");
    chk_stop_quiet: assert property (stopped |-> !ref_grant)
        else $error("reference while stopped");
    chk_halt_sticky: assert property (halted |=> halted)
        else $error("halt left without reset");
    chk_loop_operand: assert property (
        processing_state == `PSPC_ST_LOOP && ref_grant
        |-> access_class[1:0] != 2'b10) else $error("fetch in loop");
    chk_class_mode: assert property (
        ref_grant |-> access_class[2] == supervisor_mode)
        else $error("class does not match mode");
    chk_class_code: assert property (ref_grant |->
        access_class inside {3'h1, 3'h2, 3'h5, 3'h6, 3'h7})
        else $error("reserved class code");
    chk_stack_follow: assert property (
        stack_sel_supervisor == supervisor_mode) else $error("stack select");
    chk_sup_no_viol: assert property (
        privilege_violation |-> !supervisor_mode)
        else $error("violation in supervisor mode");
    chk_viol_except: assert property (privilege_violation |=>
        processing_state == `PSPC_ST_EXCEPT) else $error("no exception");
    chk_exc_super: assert property (
        $rose(processing_state == `PSPC_ST_EXCEPT) |-> ##[0:2]
        supervisor_mode) else $error("exception not supervisor");
    chk_exc_ends: assert property (
        processing_state == `PSPC_ST_EXCEPT |-> ##[1:12]
        processing_state != `PSPC_ST_EXCEPT) else $error("exception hangs");
    cov_viol: cover property (privilege_violation);
    cov_halt: cover property (halted);
    cov_stop: cover property (stopped);
    cov_loop: cover property (processing_state == `PSPC_ST_LOOP);
endmodule // pspc_ctrl_sva

bind pspc_ctrl pspc_ctrl_sva u_sva (.pclk(pclk), .presetn(presetn),
    .privilege_violation(privilege_violation), .access_class(access_class),
    .ref_grant(ref_grant), .supervisor_mode(supervisor_mode),
    .stack_sel_supervisor(stack_sel_supervisor),
    .processing_state(processing_state), .halted(halted), .stopped(stopped));

// *** tb/pspc_ctrl_tb_top.sv ***
// Self-checking bench for pspc_ctrl with an MMU model on its classes.
// Assumes zero-wait APB answers and one-cycle output lag.
`timescale 1ns/1ps
`include "pspc_defines.vh"
module pspc_ctrl_tb_top;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, instr_valid, ref_req;
    logic ref_program, ref_cpu_space, irq_pin, bus_err_pin;
    logic deny_user, err_cmd, acc, vio, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q, active_stack_pointer;
    logic [3:0] instr_class;
    logic [15:0] new_status_word;
    logic pready, pslverr, instr_accept, privilege_violation, ref_grant;
    logic supervisor_mode, stack_sel_supervisor, saved_supervisor;
    logic halted, stopped;
    logic [2:0] access_class, processing_state;
    int user_refs, mismatches = 0, n_compared = 0;
    always #10 pclk = ~pclk;
    pspc_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .instr_valid, .instr_class,
        .new_status_word, .ref_req, .ref_program, .ref_cpu_space,
        .ref_uses_sp(1'b0), .irq_pin, .bus_err_pin, .instr_accept,
        .privilege_violation, .access_class, .ref_grant, .supervisor_mode,
        .stack_sel_supervisor, .active_stack_pointer, .processing_state,
        .saved_supervisor, .halted, .stopped);
    pspc_mmu_model mmu (.pclk, .presetn, .ref_grant, .access_class,
        .deny_user, .err_cmd, .bus_err(bus_err_pin), .user_refs);
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            cmp(pready, 1);
            print_verdict();
        end
    endtask
    task automatic issue(input logic [3:0] c);
        @(posedge pclk);
        instr_valid <= 1'b1;
        instr_class <= c;
        @(posedge pclk);
        instr_valid <= 1'b0;
        #1;
        acc = instr_accept;
        vio = privilege_violation;
    endtask
    task automatic wait_st(input logic [2:0] st, input int lim);
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            #1;
            n++;
        end while (processing_state !== st && n < lim);
        cmp(processing_state, st);
        if (processing_state !== st)
            print_verdict();
    endtask
    task automatic ref_chk(input logic p, c, input logic [2:0] exp);
        @(posedge pclk);
        ref_req <= 1'b1;
        ref_program <= p;
        ref_cpu_space <= c;
        @(posedge pclk);
        #1;
        cmp(access_class, exp);
        @(posedge pclk);
        ref_req <= 1'b0;
    endtask
    task automatic pulse(input int k);
        @(posedge pclk);
        irq_pin <= 1'b1;
        repeat (k) @(posedge pclk);
        irq_pin <= 1'b0;
    endtask
    initial begin
        #200000;
        mismatches++;
        print_verdict();
    end
    initial begin
        {presetn, psel, penable, pwrite, instr_valid, ref_req} = '0;
        {ref_program, ref_cpu_space, irq_pin, deny_user, err_cmd} = '0;
        {paddr, pwdata, instr_class} = '0;
        new_status_word = 16'h2700;
        repeat (3) @(posedge pclk);
        cmp(supervisor_mode, 1);
        cmp(processing_state, `PSPC_ST_EXCEPT);
        presetn <= 1'b1;
        wait_st(`PSPC_ST_NORMAL, 20);
        apb(1, `PSPC_ADDR_STATUS_WORD, 32'h0000_0000);
        apb(0, `PSPC_ADDR_STATUS_WORD, 32'h0);
        cmp(q, 32'h0000_2700);
        apb(0, 12'h040, 32'h0);
        cmp(e, 1);
        apb(1, `PSPC_ADDR_USP, 32'h0000_1230);
        apb(1, `PSPC_ADDR_SSP, 32'h0000_8000);
        apb(1, `PSPC_ADDR_CTRL, 32'h0000_0001);
        cmp(active_stack_pointer, 32'h0000_8000);
        for (int c = 2; c <= 8; c++) begin
            if (c == 3)
                continue;
            issue(c[3:0]);
            cmp({acc, vio}, 2'b10);
        end
        ref_chk(1, 0, `PSPC_FC_SUP_PROG);
        ref_chk(0, 0, `PSPC_FC_SUP_DATA);
        ref_chk(0, 1, `PSPC_FC_CPU);
        issue(`PSPC_OP_LOOP);
        wait_st(`PSPC_ST_LOOP, 4);
        ref_chk(1, 0, `PSPC_FC_NONE);
        ref_chk(0, 0, `PSPC_FC_SUP_DATA);
        issue(`PSPC_OP_PLAIN);
        wait_st(`PSPC_ST_NORMAL, 4);
        issue(`PSPC_OP_WAIT);
        wait_st(`PSPC_ST_STOPPED, 4);
        cmp({stopped, halted}, 2'b10);
        ref_chk(0, 0, `PSPC_FC_NONE);
        pulse(3);
        wait_st(`PSPC_ST_EXCEPT, 10);
        wait_st(`PSPC_ST_NORMAL, 20);
        @(posedge pclk);
        new_status_word <= 16'h0700;
        for (int c = 1; c <= 9; c++) begin
            issue(`PSPC_OP_WRITE_SW);
            repeat (2) @(posedge pclk);
            cmp(supervisor_mode, 0);
            if (c == 9)
                break;
            issue(c[3:0]);
            cmp({acc, vio}, 2'b01);
            wait_st(`PSPC_ST_EXCEPT, 4);
            apb(0, `PSPC_ADDR_CAUSE, 32'h0);
            cmp(q, 32'h0000_0003);
            wait_st(`PSPC_ST_NORMAL, 20);
            cmp({supervisor_mode, saved_supervisor}, 2'b10);
        end
        cmp(active_stack_pointer, 32'h0000_1230);
        issue(`PSPC_OP_PLAIN);
        cmp({acc, vio, supervisor_mode}, 3'b100);
        ref_chk(1, 0, `PSPC_FC_USER_PROG);
        @(posedge pclk);
        deny_user <= 1'b1;
        ref_chk(0, 0, `PSPC_FC_USER_DATA);
        @(posedge pclk);
        deny_user <= 1'b0;
        err_cmd <= 1'b1;
        repeat (2) @(posedge pclk);
        err_cmd <= 1'b0;
        wait_st(`PSPC_ST_HALTED, 20);
        cmp(user_refs > 0, 1);
        pulse(3);
        issue(`PSPC_OP_PLAIN);
        cmp({acc, halted}, 2'b01);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        wait_st(`PSPC_ST_NORMAL, 20);
        cmp({halted, supervisor_mode}, 2'b01);
        print_verdict();
    end
endmodule // pspc_ctrl_tb_top

// *** tb/pspc_mmu_model.sv ***
// Memory management unit model watching the access class lines.
// Assumes pclk-synchronous core outputs; bus_err feeds the core's pin.
`timescale 1ns/1ps
`include "pspc_defines.vh"
module pspc_mmu_model (
    input wire pclk,
    input wire presetn,
    input wire ref_grant,
    input wire [2:0] access_class,
    input wire deny_user,
    input wire err_cmd,
    output logic bus_err,
    output int user_refs
);
    logic was_grant;
    // One pulse per denied reference, so a held request is one fault
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_err <= 1'b0;
            was_grant <= 1'b0;
            user_refs <= 0;
        end else begin
            was_grant <= ref_grant;
            if (ref_grant && !was_grant && !access_class[2]) begin
                user_refs <= user_refs + 1;
            end
            bus_err <= err_cmd || (deny_user && ref_grant && !was_grant &&
                !access_class[2]);
        end
    end
endmodule // pspc_mmu_model
